//--- disr_defines.vh
// Constants for the identify and health-report responder.
// Assumes inclusion by its bare name from the responder module and the bench.
`ifndef DISR_DEFINES_VH
`define DISR_DEFINES_VH

// ******************************************************************
// Register byte addresses
// ******************************************************************
`define DISR_ADDR_CMD        12'h000
`define DISR_ADDR_STATUS     12'h004
`define DISR_ADDR_CYL        12'h008
`define DISR_ADDR_ID_BASE    12'h400
`define DISR_ADDR_HR_BASE    12'h800
`define DISR_ADDR_HR_END     12'hA00

// ******************************************************************
// Status fields and health subcommands
// ******************************************************************
`define DISR_ST_DONE         0
`define DISR_ST_ABORT        1
`define DISR_ST_ENABLED      2
`define DISR_SUB_READ_DATA   8'hD0
`define DISR_SUB_THRESH      8'hD1
`define DISR_SUB_AUTOSAVE    8'hD2
`define DISR_SUB_SAVE        8'hD3
`define DISR_SUB_OFFLINE     8'hD4
`define DISR_SUB_READ_LOG    8'hD5
`define DISR_SUB_WRITE_LOG   8'hD6
`define DISR_SUB_ENABLE      8'hD8
`define DISR_SUB_DISABLE     8'hD9
`define DISR_SUB_STATUS      8'hDA
`define DISR_CYL_GOOD        16'hC24F
`define DISR_CYL_EXCEEDED    16'h2CF4
`define DISR_CYL_RESET       16'h0000

// ******************************************************************
// Identify words
// ******************************************************************
`define DISR_ID_W59          16'h0101
`define DISR_ID_MDMA         16'h0207
`define DISR_ID_PIO_MODES    16'h0003
`define DISR_ID_CYCLE_TIME   16'h0078
`define DISR_ID_W69          16'h4000
`define DISR_ID_QDEPTH       16'h001F
`define DISR_ID_LINK_CAP     16'h030E
`define DISR_ID_LINK_CAP2    16'h0080
`define DISR_ID_LINK_FEAT    16'h0148
`define DISR_ID_W79          16'h0040
`define DISR_ID_MAJOR        16'h03FC
`define DISR_ID_CMDSET0      16'h702B
`define DISR_ID_CMDSET1      16'h7500
`define DISR_ID_CMDSET2      16'h4002
`define DISR_ID_UDMA         16'h007F
`define DISR_ID_ERASE_NORM   16'h0003
`define DISR_ID_ERASE_ENH    16'h0001
`define DISR_ID_MASTER_PW    16'hFFFE
`define DISR_ID_DSM_BLOCKS   16'h0100
`define DISR_ID_SECURITY     16'h0009
`define DISR_ID_DSM_SUP      16'h0001
`define DISR_ID_NONROT       16'h0001
`define DISR_ID_TRANSPORT    16'h107F
`define DISR_ID_SIGNATURE    8'hA5

// ******************************************************************
// Health data structure
// ******************************************************************
`define DISR_HR_REVISION     16'h0001
`define DISR_HR_ATTR_FIRST   9'd2
`define DISR_HR_ATTR_LAST    9'd361
`define DISR_HR_ATTR_LEN     9'd12
`define DISR_HR_ATTR_NORM    8'h64
`define DISR_HR_OFFLINE_CAP  8'h00
`define DISR_HR_SMART_CAP    16'h0003
`define DISR_HR_ERRLOG       8'h01
`define DISR_HR_POLL_SHORT   8'h02
`define DISR_HR_POLL_EXT     8'h0A
`define DISR_HR_POLL_CONV    8'h05
// Arbitrary neutral model tag for bytes 400 to 405.
`define DISR_HR_MODEL_TAG    48'h4E4555545241

`endif

//--- disr_responder.v
// Identify upper half and health-report responder behind an APB slave.
// Assumes event pulses and state inputs come from logic on clk, and the
// lower identify block supplies the byte sum of identify words 0 to 58.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "disr_defines.vh"

module disr_responder (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output reg         pslverr,
   // Drive state from the surrounding controller
   input  wire        hostWrite32Mb,
   input  wire        hostRead32Mb,
   input  wire        flashWrite32Mb,
   input  wire        uncorrSector,
   input  wire        reserveBelowThresh,
   input  wire [15:0] offlineTimeSec,
   input  wire [31:0] lba28Count,
   input  wire [63:0] maxLba48,
   input  wire [7:0]  lowerIdSum
);

   // ******************************************************************
   // Decoding functions
   // ******************************************************************
   function [7:0] attrId;
      input [4:0] n;
      begin
         case (n)
            5'd0:    attrId = 8'h01;
            5'd1:    attrId = 8'h05;
            5'd2:    attrId = 8'h09;
            5'd3:    attrId = 8'h0C;
            5'd4:    attrId = 8'hA0;
            5'd5:    attrId = 8'hA1;
            5'd6:    attrId = 8'hA3;
            5'd7:    attrId = 8'hA4;
            5'd8:    attrId = 8'hA5;
            5'd9:    attrId = 8'hA6;
            5'd10:   attrId = 8'hA7;
            5'd11:   attrId = 8'hA8;
            5'd12:   attrId = 8'hA9;
            5'd13:   attrId = 8'hAF;
            5'd14:   attrId = 8'hB0;
            5'd15:   attrId = 8'hB1;
            5'd16:   attrId = 8'hB2;
            5'd17:   attrId = 8'hB5;
            5'd18:   attrId = 8'hB6;
            5'd19:   attrId = 8'hC0;
            5'd20:   attrId = 8'hC2;
            5'd21:   attrId = 8'hC3;
            5'd22:   attrId = 8'hC4;
            5'd23:   attrId = 8'hC5;
            5'd24:   attrId = 8'hC6;
            5'd25:   attrId = 8'hC7;
            5'd26:   attrId = 8'hE8;
            5'd27:   attrId = 8'hF1;
            5'd28:   attrId = 8'hF2;
            5'd29:   attrId = 8'hF5;
            default: attrId = 8'h00;
         endcase
      end
   endfunction

   // Raw byte r of an attribute; v packs {uncorr, f5, f2, f1}.
   function [7:0] attrRaw;
      input [7:0]   id;
      input [2:0]   r;
      input [175:0] v;
      reg   [47:0]  cnt;
      begin
         cnt = 48'h000000000000;
         case (id)
            8'hF1:   cnt = v[47:0];
            8'hF2:   cnt = v[95:48];
            8'hF5:   cnt = v[143:96];
            8'hA0:   cnt = {16'h0000, v[175:144]};
            default: cnt = 48'h000000000000;
         endcase
         attrRaw = cnt[8*r +: 8];
      end
   endfunction

   localparam [15:0] HR_REV = `DISR_HR_REVISION;
   localparam [15:0] HR_CAP = `DISR_HR_SMART_CAP;
   localparam [47:0] HR_TAG = `DISR_HR_MODEL_TAG;
   function [7:0] healthByte;
      input [8:0]   idx;
      input [175:0] v;
      input [15:0]  tsec;
      reg   [8:0]   off;
      reg   [8:0]   ent;
      reg   [8:0]   pos;
      reg   [7:0]   id;
      begin
         off = idx - `DISR_HR_ATTR_FIRST;
         ent = off / `DISR_HR_ATTR_LEN;
         pos = off - ent * `DISR_HR_ATTR_LEN;
         id  = attrId(ent[4:0]);
         healthByte = 8'h00;
         if (idx >= `DISR_HR_ATTR_FIRST && idx <= `DISR_HR_ATTR_LAST) begin
            case (pos[3:0])
               4'd0:    healthByte = id;
               4'd3:    healthByte = `DISR_HR_ATTR_NORM;
               4'd4:    healthByte = `DISR_HR_ATTR_NORM;
               4'd5:    healthByte = attrRaw(id, 3'd0, v);
               4'd6:    healthByte = attrRaw(id, 3'd1, v);
               4'd7:    healthByte = attrRaw(id, 3'd2, v);
               4'd8:    healthByte = attrRaw(id, 3'd3, v);
               4'd9:    healthByte = attrRaw(id, 3'd4, v);
               4'd10:   healthByte = attrRaw(id, 3'd5, v);
               default: healthByte = 8'h00;
            endcase
         end else begin
            case (idx)
               9'd0:    healthByte = HR_REV[7:0];
               9'd1:    healthByte = HR_REV[15:8];
               9'd364:  healthByte = tsec[7:0];
               9'd365:  healthByte = tsec[15:8];
               9'd367:  healthByte = `DISR_HR_OFFLINE_CAP;
               9'd368:  healthByte = HR_CAP[7:0];
               9'd369:  healthByte = HR_CAP[15:8];
               9'd370:  healthByte = `DISR_HR_ERRLOG;
               9'd372:  healthByte = `DISR_HR_POLL_SHORT;
               9'd373:  healthByte = `DISR_HR_POLL_EXT;
               9'd374:  healthByte = `DISR_HR_POLL_CONV;
               9'd400:  healthByte = HR_TAG[47:40];
               9'd401:  healthByte = HR_TAG[39:32];
               9'd402:  healthByte = HR_TAG[31:24];
               9'd403:  healthByte = HR_TAG[23:16];
               9'd404:  healthByte = HR_TAG[15:8];
               9'd405:  healthByte = HR_TAG[7:0];
               default: healthByte = 8'h00;
            endcase
         end
      end
   endfunction

   function [15:0] idWord;
      input [7:0]  w;
      input [31:0] cap28;
      input [63:0] cap48;
      begin
         case (w)
            8'd59:   idWord = `DISR_ID_W59;
            8'd60:   idWord = cap28[15:0];
            8'd61:   idWord = cap28[31:16];
            8'd63:   idWord = `DISR_ID_MDMA;
            8'd64:   idWord = `DISR_ID_PIO_MODES;
            8'd65:   idWord = `DISR_ID_CYCLE_TIME;
            8'd66:   idWord = `DISR_ID_CYCLE_TIME;
            8'd67:   idWord = `DISR_ID_CYCLE_TIME;
            8'd68:   idWord = `DISR_ID_CYCLE_TIME;
            8'd69:   idWord = `DISR_ID_W69;
            8'd75:   idWord = `DISR_ID_QDEPTH;
            8'd76:   idWord = `DISR_ID_LINK_CAP;
            8'd77:   idWord = `DISR_ID_LINK_CAP2;
            8'd78:   idWord = `DISR_ID_LINK_FEAT;
            8'd79:   idWord = `DISR_ID_W79;
            8'd80:   idWord = `DISR_ID_MAJOR;
            8'd82:   idWord = `DISR_ID_CMDSET0;
            8'd83:   idWord = `DISR_ID_CMDSET1;
            8'd84:   idWord = `DISR_ID_CMDSET2;
            8'd88:   idWord = `DISR_ID_UDMA;
            8'd89:   idWord = `DISR_ID_ERASE_NORM;
            8'd90:   idWord = `DISR_ID_ERASE_ENH;
            8'd92:   idWord = `DISR_ID_MASTER_PW;
            8'd100:  idWord = cap48[15:0];
            8'd101:  idWord = cap48[31:16];
            8'd102:  idWord = cap48[47:32];
            8'd103:  idWord = cap48[63:48];
            8'd105:  idWord = `DISR_ID_DSM_BLOCKS;
            8'd128:  idWord = `DISR_ID_SECURITY;
            8'd169:  idWord = `DISR_ID_DSM_SUP;
            8'd217:  idWord = `DISR_ID_NONROT;
            8'd222:  idWord = `DISR_ID_TRANSPORT;
            default: idWord = 16'h0000;
         endcase
      end
   endfunction

   // ******************************************************************
   // Usage counters and snapshot
   // ******************************************************************
   reg [47:0]  hostWriteCnt;
   reg [47:0]  hostReadCnt;
   reg [47:0]  flashWriteCnt;
   reg [31:0]  uncorrCnt;
   reg [175:0] snap;

   always @(posedge clk) begin
      if (rst) begin
         hostWriteCnt  <= 48'h000000000000;
         hostReadCnt   <= 48'h000000000000;
         flashWriteCnt <= 48'h000000000000;
         uncorrCnt     <= 32'h00000000;
      end else begin
         if (hostWrite32Mb) begin
            hostWriteCnt <= hostWriteCnt + 48'h000000000001;
         end
         if (hostRead32Mb) begin
            hostReadCnt <= hostReadCnt + 48'h000000000001;
         end
         if (flashWrite32Mb) begin
            flashWriteCnt <= flashWriteCnt + 48'h000000000001;
         end
         if (uncorrSector) begin
            uncorrCnt <= uncorrCnt + 32'h00000001;
         end
      end
   end

   // ******************************************************************
   // Checksums
   // ******************************************************************
   reg [7:0]  healthSum;
   reg [7:0]  idSum;
   reg [15:0] idWordVal;
   integer    i;

   // Sums fold to a handful of adders since most bytes are constants.
   always @* begin
      healthSum = 8'h00;
      idSum     = lowerIdSum + `DISR_ID_SIGNATURE;
      idWordVal = 16'h0000;
      for (i = 0; i < 511; i = i + 1) begin
         healthSum = healthSum + healthByte(i[8:0], snap, offlineTimeSec);
      end
      for (i = 59; i < 255; i = i + 1) begin
         idWordVal = idWord(i[7:0], lba28Count, maxLba48);
         idSum     = idSum + idWordVal[7:0] + idWordVal[15:8];
      end
   end

   // ******************************************************************
   // APB access and subcommand execution
   // ******************************************************************
   reg        smartOn;
   reg        cmdDone;
   reg        cmdAbort;
   reg [15:0] cylinder;
   reg [31:0] next_rdata;
   reg        next_err;
   reg [8:0]  hb;
   reg [7:0]  hbyte [0:3];
   integer    k;

   wire        setup   = psel & ~penable;
   wire        wrTake  = psel & penable & pwrite;
   wire [7:0]  sub     = pwdata[7:0];
   wire [11:0] idOff   = paddr - `DISR_ADDR_ID_BASE;
   wire [11:0] hrOff   = paddr - `DISR_ADDR_HR_BASE;

   // Zero wait states: read data is staged in the setup cycle.
   assign pready = 1'b1;

   always @* begin
      hb = {hrOff[8:2], 2'b00};
      for (k = 0; k < 4; k = k + 1) begin
         hbyte[k] = healthByte(hb + k[8:0], snap, offlineTimeSec);
      end
      if (hrOff[8:2] == 7'h7F) begin
         hbyte[3] = 8'h00 - healthSum;
      end
      next_rdata = 32'h00000000;
      next_err   = 1'b0;
      if (paddr[1:0] != 2'b00) begin
         next_err = 1'b1;
      end else if (paddr == `DISR_ADDR_CMD) begin
         next_rdata = 32'h00000000;
      end else if (paddr == `DISR_ADDR_STATUS) begin
         next_rdata[`DISR_ST_DONE]    = cmdDone;
         next_rdata[`DISR_ST_ABORT]   = cmdAbort;
         next_rdata[`DISR_ST_ENABLED] = smartOn;
      end else if (paddr == `DISR_ADDR_CYL) begin
         next_rdata = {16'h0000, cylinder};
      end else if (paddr >= `DISR_ADDR_ID_BASE && paddr < `DISR_ADDR_HR_BASE) begin
         if (pwrite) begin
            next_err = 1'b1;
         end else if (idOff[9:2] == 8'hFF) begin
            next_rdata = {16'h0000, 8'h00 - idSum, `DISR_ID_SIGNATURE};
         end else begin
            next_rdata = {16'h0000, idWord(idOff[9:2], lba28Count, maxLba48)};
         end
      end else if (paddr >= `DISR_ADDR_HR_BASE && paddr < `DISR_ADDR_HR_END) begin
         next_err   = pwrite;
         next_rdata = {hbyte[3], hbyte[2], hbyte[1], hbyte[0]};
      end else begin
         next_err = 1'b1;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         prdata   <= 32'h00000000;
         pslverr  <= 1'b0;
         smartOn  <= 1'b1;
         cmdDone  <= 1'b0;
         cmdAbort <= 1'b0;
         cylinder <= `DISR_CYL_RESET;
         snap     <= 176'h0;
      end else begin
         if (setup) begin
            prdata  <= pwrite ? 32'h00000000 : next_rdata;
            pslverr <= next_err;
         end
         if (wrTake && paddr == `DISR_ADDR_CMD) begin
            cmdDone  <= 1'b1;
            cmdAbort <= 1'b0;
            case (sub)
               `DISR_SUB_ENABLE:  smartOn <= 1'b1;
               `DISR_SUB_DISABLE: smartOn <= 1'b0;
               `DISR_SUB_STATUS: begin
                  if (!smartOn) begin
                     cmdAbort <= 1'b1;
                  end else begin
                     cylinder <= reserveBelowThresh ? `DISR_CYL_EXCEEDED : `DISR_CYL_GOOD;
                  end
               end
               `DISR_SUB_READ_DATA: begin
                  if (!smartOn) begin
                     cmdAbort <= 1'b1;
                  end else begin
                     snap <= {uncorrCnt, flashWriteCnt, hostReadCnt, hostWriteCnt};
                  end
               end
               `DISR_SUB_THRESH, `DISR_SUB_AUTOSAVE, `DISR_SUB_SAVE, `DISR_SUB_OFFLINE,
               `DISR_SUB_READ_LOG, `DISR_SUB_WRITE_LOG: begin
                  // Handled by firmware elsewhere; only refused while disabled.
                  cmdAbort <= ~smartOn;
               end
               default: cmdAbort <= 1'b1;
            endcase
         end
      end
   end

endmodule

//--- disr_responder_checker.sv
// Concurrent checks on the identify and health-report responder.
// Assumes it is bound to the responder and sees only its ports.
`timescale 1ns/1ps
module disr_responder_checker (
   // Clock and reset
   input wire        clk,
   input wire        rst,
   // Register bus
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pslverr,
   // Drive state
   input wire [15:0] offlineTimeSec,
   input wire [31:0] lba28Count,
   input wire [63:0] maxLba48
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   wire        rdSetup;
   reg  [11:0] addrPrev;
   reg  [15:0] offPrev;
   reg  [31:0] lbaPrev;
   reg  [63:0] maxPrev;

   assign rdSetup = psel && !penable && !pwrite;

   // Read data is staged from what the inputs held at the setup edge.
   always @(posedge clk) begin
      addrPrev <= paddr;
      offPrev  <= offlineTimeSec;
      lbaPrev  <= lba28Count;
      maxPrev  <= maxLba48;
   end

   property idWord(a, v);
      rdSetup && paddr == a |=> prdata == {16'h0000, v};
   endproperty

   // ******************************************************************
   // Assertions
   // ******************************************************************
   AST_MDMA_MODES: assert property (idWord(12'h4FC, 16'h0207))
      else $error("word 63 wrong");
   AST_CYCLE_TIME: assert property (rdSetup && paddr >= 12'h504 && paddr <= 12'h510 && paddr[1:0] == 2'b00 |=> prdata == 32'h0000_0078)
      else $error("cycle time word wrong");
   AST_LINK_CAP: assert property (idWord(12'h530, 16'h030E))
      else $error("word 76 wrong");
   AST_ERASE: assert property (rdSetup && (paddr == 12'h564 || paddr == 12'h568) |=> prdata == (addrPrev == 12'h564 ? 32'h3 : 32'h1))
      else $error("erase time word wrong");
   AST_LBA28: assert property (rdSetup && paddr[11:3] == 9'h09E && paddr[1:0] == 2'b00 |=>
      prdata == {16'h0000, lbaPrev[16 * addrPrev[2] +: 16]})
      else $error("sector count word wrong");
   AST_LBA48: assert property (rdSetup && paddr[11:4] == 8'h59 && paddr[1:0] == 2'b00 |=> prdata[15:0] == maxPrev[16 * addrPrev[3:2] +: 16])
      else $error("max address word wrong");
   AST_TRANSPORT: assert property (idWord(12'h778, 16'h107F))
      else $error("word 222 wrong");
   AST_OFFLINE: assert property (rdSetup && paddr == 12'h96C |=> prdata[15:0] == offPrev)
      else $error("offline time wrong");
   AST_POLL: assert property (rdSetup && paddr == 12'h974 |=> prdata == 32'h0005_0A02)
      else $error("polling bytes wrong");
   AST_RESERVED: assert property (rdSetup && paddr inside {12'h978, 12'h97C, 12'h980} |=> prdata[15:0] == 16'h0 && (addrPrev == 12'h980 || prdata[31:16] == 16'h0))
      else $error("reserved bytes not zero");
   AST_HOLD: assert property (!(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
      else $error("read data moved outside setup");

   cover property (psel && penable && pwrite && paddr == 12'h000 && pwdata[7:0] == 8'hD0);
   cover property (rdSetup && paddr == 12'h9FC);
   cover property (psel && penable && pslverr);
endmodule

bind disr_responder disr_responder_checker chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pslverr, .offlineTimeSec, .lba28Count, .maxLba48);

//--- disr_drive_model.sv
// Stand-in for the controller logic that feeds drive state to the responder.
// Assumes its tasks are called from a process that runs on clk.
`timescale 1ns/1ps
module disr_drive_model #(
   parameter logic [31:0] LBA28   = 32'h0000_1000,
   parameter logic [63:0] LBA48   = 64'h0000_0000_0000_1000,
   parameter logic [15:0] OFFLINE = 16'h0001,
   parameter logic [7:0]  LOWSUM  = 8'h00
) (
   // Clock
   input  logic        clk,
   // Event pulses
   output logic        hostWrite32Mb,
   output logic        hostRead32Mb,
   output logic        flashWrite32Mb,
   output logic        uncorrSector,
   // Levels
   output logic        reserveBelowThresh,
   output logic [15:0] offlineTimeSec,
   output logic [31:0] lba28Count,
   output logic [63:0] maxLba48,
   output logic [7:0]  lowerIdSum
);
   logic [3:0] evt = 4'h0;

   initial reserveBelowThresh = 1'b0;
   assign {uncorrSector, flashWrite32Mb, hostRead32Mb, hostWrite32Mb} = evt;
   assign offlineTimeSec = OFFLINE;
   assign lba28Count     = LBA28;
   assign maxLba48       = LBA48;
   assign lowerIdSum     = LOWSUM;

   // one unit per high cycle
   // High cycles run back to back, the hardest case for a counter.
   task pulse(input int kind, input int n);
      @(posedge clk);
      evt <= 4'h1 << kind;
      repeat (n) @(posedge clk);
      evt <= 4'h0;
   endtask

   task setThresh(input logic v);
      @(posedge clk);
      reserveBelowThresh <= v;
   endtask
endmodule

//--- disr_responder_bench.sv
// Self-checking bench for the identify and health-report responder.
// Assumes the drive model feeds the state inputs and the checker is bound.
`timescale 1ns/1ps
`include "disr_defines.vh"
module disr_responder_bench;
   localparam logic [31:0] LBA28  = 32'h0EE7_C2B0;
   localparam logic [63:0] LBA48  = 64'h0000_0001_DCFC_4E31;
   localparam logic [15:0] OFFLINE = 16'h0E10;
   localparam logic [7:0]  LOWSUM = 8'h5C;
   localparam logic [7:0]  ATTR [0:3] = '{8'hF1, 8'hF2, 8'hF5, 8'hA0};
   localparam logic [31:0] ID_TAB [0:11] = '{32'h003F_0207, 32'h0041_0078, 32'h0042_0078, 32'h0043_0078,
      32'h0044_0078, 32'h004C_030E, 32'h004E_0148, 32'h0058_007F, 32'h0059_0003, 32'h005A_0001, 32'h0069_0100,
      32'h00DE_107F};

   logic        clk, rst, psel, penable, pwrite, rdErr;
   logic [11:0] paddr;
   logic [31:0] pwdata, rdVal;
   logic [7:0]  sum;
   logic [15:0] idw [0:255];
   logic [7:0]  hb [0:511];
   logic [47:0] cnt [0:3];
   wire         pready, pslverr, hostWrite32Mb, hostRead32Mb, flashWrite32Mb, uncorrSector, reserveBelowThresh;
   wire  [31:0] prdata, lba28Count;
   wire  [15:0] offlineTimeSec;
   wire  [63:0] maxLba48;
   wire  [7:0]  lowerIdSum;
   int          mismatches, checked;

   disr_responder dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
      .hostWrite32Mb, .hostRead32Mb, .flashWrite32Mb, .uncorrSector, .reserveBelowThresh, .offlineTimeSec,
      .lba28Count, .maxLba48, .lowerIdSum);
   disr_drive_model #(.LBA28(LBA28), .LBA48(LBA48), .OFFLINE(OFFLINE), .LOWSUM(LOWSUM)) model (.clk,
      .hostWrite32Mb, .hostRead32Mb, .flashWrite32Mb, .uncorrSector, .reserveBelowThresh, .offlineTimeSec,
      .lba28Count, .maxLba48, .lowerIdSum);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ******************************************************************
   // Bus and checking tasks
   // ******************************************************************
   task check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One transfer; the request stays put until pready is sampled high.
   task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rdVal = prdata;
      rdErr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task pulses(input int j, input int n);
      model.pulse(j, n);
      cnt[j] = cnt[j] + n;
   endtask

   task health;
      logic [47:0] raw;
      int          found;
      xfer(1'b1, 12'h000, 32'h0000_00D0);
      sum   = 8'h00;
      found = 0;
      for (int k = 0; k < 512; k++) begin
         if (k % 4 == 0)
            xfer(1'b0, 12'(12'h800 + k), 32'h0);
         hb[k] = rdVal[8 * (k % 4) +: 8];
         sum   = sum + hb[k];
      end
      check(sum, 8'h00);
      check(hb[2], 8'h01);
      check({hb[365], hb[364]}, OFFLINE);
      check(hb[370], 8'h01);
      check({hb[374], hb[373], hb[372]}, 24'h05_0A02);
      for (int b = 375; b <= 385; b++)
         check(hb[b], 8'h00);
      for (int e = 2; e < 362; e += 12)
         for (int j = 0; j < 4; j++)
            if (hb[e] === ATTR[j]) begin
               for (int r = 0; r < 6; r++)
                  raw[8 * r +: 8] = hb[e + 5 + r];
               check(raw, cnt[j]);
               found++;
            end
      check(found, 4);
   endtask

   task summarize;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      $display("mismatch at %0t: watchdog expired", $time);
      summarize();
   end

   // ******************************************************************
   // Test sequence
   // ******************************************************************
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 3'b000, 12'h000, 32'h0};
      {mismatches, checked} = {32'sd0, 32'sd0};
      for (int j = 0; j < 4; j++)
         cnt[j] = 48'h0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      xfer(1'b0, 12'h004, 32'h0);
      check(rdVal, 32'h0000_0004);
      xfer(1'b0, 12'h008, 32'h0);
      check(rdVal, 32'h0000_0000);
      sum = LOWSUM;
      for (int w = 0; w < 256; w++) begin
         xfer(1'b0, 12'(12'h400 + 4 * w), 32'h0);
         idw[w] = rdVal[15:0];
         sum    = sum + rdVal[7:0] + rdVal[15:8];
      end
      for (int i = 0; i < 12; i++)
         check(idw[ID_TAB[i][31:16]], ID_TAB[i][15:0]);
      check({idw[61], idw[60]}, LBA28);
      check({idw[103], idw[102], idw[101], idw[100]}, LBA48);
      check(idw[255][7:0], `DISR_ID_SIGNATURE);
      check(sum, 8'h00);
      for (int r = 1; r < 3; r++) begin
         for (int j = 0; j < 4; j++)
            pulses(j, r + 2 * j);
         health();
      end
      for (int t = 0; t < 2; t++) begin
         model.setThresh(t[0]);
         xfer(1'b1, 12'h000, 32'h0000_00DA);
         xfer(1'b0, 12'h008, 32'h0);
         check(rdVal, t ? 32'h0000_2CF4 : 32'h0000_C24F);
      end
      // Walks every subcommand code; D7 is unknown and DA comes while disabled.
      for (logic [7:0] c = 8'hD0; c <= 8'hDA; c++) begin
         xfer(1'b1, 12'h000, {24'h0, c});
         xfer(1'b0, 12'h004, 32'h0);
         check(rdVal, c == 8'hD7 ? 32'h7 : c == 8'hD9 ? 32'h1 : c == 8'hDA ? 32'h3 : 32'h5);
      end
      xfer(1'b0, 12'h008, 32'h0);
      check(rdVal, 32'h0000_2CF4);
      xfer(1'b1, 12'h000, 32'h0000_00D8);
      xfer(1'b0, 12'h00C, 32'h0);
      check(rdErr, 1'b1);
      xfer(1'b0, 12'h402, 32'h0);
      check(rdErr, 1'b1);
      xfer(1'b1, 12'h4FC, 32'h0);
      check(rdErr, 1'b1);
      xfer(1'b0, 12'h4FC, 32'h0);
      check({rdErr, rdVal}, {1'b0, 32'h0000_0207});
      summarize();
   end
endmodule
